// ===== hdl/swc_sleep_wake_control.sv
// sleep and wake controller with apb register access
//
// Notes on behaviour
// - resume-mode bit 5 of power control chooses wake
// - mode 0: enabled interrupts wake, branch vector
// - mode 1: any flag the sleep state allows wakes, mask ignored, resume inline
// - power control bit layout, bit 7 to 0
// - all six sources end idle, clock restored
// - soft sleep: externals, externally clocked timers only
// - low external pin sets flag, oscillator restarts
// - mode 0, all disabled: only reset pin wakes
// - wake enables taken from mask before sleep
// - inline wake leaves flags; software write clears
// - float bit at deep sleep entry floats ports
// - falling deep sleep input enters deep sleep
// - reset after deep sleep restarts oscillator, address 0
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module swc_sleep_wake_control #(
    parameter int RESET_MIN_CYC = swc_pkg::SWC_RESET_MIN_CYC
) (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, active low
    input wire swc_pkg::swc_apb_req_s apb_req, // apb request
    output swc_pkg::swc_apb_rsp_s apb_rsp, // apb response
    input wire swc_pkg::swc_irq_src_s irq_src, // interrupt sources
    input wire logic deep_sleep_request_n, // shared timer one pin
    input wire logic reset_pin, // core reset pin, active high
    output swc_pkg::swc_core_ctl_s core_ctl // clock, oscillator, wake
);
    import swc_pkg::*;

    if (RESET_MIN_CYC < 1 || RESET_MIN_CYC > 255)
    begin : g_bad_param
        $error("RESET_MIN_CYC out of range");
    end

    typedef struct packed {
        swc_mode_e mode;
        logic [7:0] power_ctrl;
        logic [7:0] irq_mask;
        logic [7:0] port_ctrl;
        logic [5:0] flags;
        logic [7:0] mask_snap;
        logic float_q;
        logic deep_in_prev;
        logic [7:0] rst_cnt;
        logic [31:0] prdata;
        logic wake_vector;
        logic wake_inline;
        logic [2:0] vector_idx;
        logic core_restart;
    } swc_regs_s;

    localparam swc_regs_s SWC_REGS_RST = '{
        mode: SWC_RUN,
        power_ctrl: SWC_POWER_CTRL_RST,
        irq_mask: SWC_IRQ_MASK_RST,
        port_ctrl: SWC_PORT_CTRL_RST,
        flags: 6'h00,
        mask_snap: SWC_IRQ_MASK_RST,
        float_q: 1'b0,
        deep_in_prev: 1'b1,
        rst_cnt: 8'h00,
        prdata: 32'h0000_0000,
        wake_vector: 1'b0,
        wake_inline: 1'b0,
        vector_idx: 3'h0,
        core_restart: 1'b0
    };

    swc_regs_s r_q;
    swc_regs_s r_d;

    // word index from byte address; flags a misaligned or out-of-range address
    function automatic logic [8:0] word_index(input logic [SWC_ADDR_W-1:0] addr);
        logic [8:0] res;
        res = {1'b0, addr[9:2]};
        if (addr[1:0] != 2'b00 || addr[SWC_ADDR_W-1:10] != '0)
        begin
            res[8] = 1'b1;
        end
        return res;
    endfunction : word_index

    // lowest numbered set bit, used for vector selection
    function automatic logic [2:0] first_set(input logic [5:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = SWC_NUM_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : first_set

    function automatic logic is_mapped(input logic [8:0] w);
        return !w[8] && (w[7:0] == SWC_IDX_FLAGS || w[7:0] == SWC_IDX_STATUS
            || w[7:0] == SWC_IDX_POWER_CTRL || w[7:0] == SWC_IDX_IRQ_MASK
            || w[7:0] == SWC_IDX_PORT_CTRL);
    endfunction : is_mapped

    logic [8:0] widx;
    logic access;
    logic setup;
    logic [5:0] flag_set;
    logic [5:0] wake_allowed;
    logic [5:0] enabled_hits;
    logic [5:0] any_hits;
    logic sleeping;

    always_comb
    begin
        widx = word_index(apb_req.paddr);
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable;
        sleeping = (r_q.mode == SWC_IDLE) || (r_q.mode == SWC_SOFT);

        // hardware flag sources; external pins are level sensitive, active low
        flag_set = 6'h00;
        flag_set[SWC_SRC_EXT0] = !irq_src.ext_irq_zero_n;
        flag_set[SWC_SRC_EXT1] = !irq_src.ext_irq_one_n;
        flag_set[SWC_SRC_TMR0] = irq_src.tmr0_overflow;
        flag_set[SWC_SRC_TMR1] = irq_src.tmr1_overflow;
        flag_set[SWC_SRC_SERIAL] = irq_src.serial_event;
        flag_set[SWC_SRC_TMR2] = irq_src.tmr2_event;

        // sources that may end the present sleep state
        if (r_q.mode == SWC_SOFT)
        begin
            wake_allowed = SWC_SOFT_WAKE_SRCS;
            wake_allowed[SWC_SRC_TMR0] = irq_src.tmr0_ext_clock;
            wake_allowed[SWC_SRC_TMR1] = irq_src.tmr1_ext_clock;
        end
        else
        begin
            wake_allowed = 6'h3F;
        end
        any_hits = r_q.flags & wake_allowed;
        // mask snapshot from sleep entry; global enable gates all
        enabled_hits = any_hits & r_q.mask_snap[SWC_NUM_SRC-1:0]
            & {SWC_NUM_SRC{r_q.mask_snap[SWC_IRQ_GLOBAL_POS]}};
    end

    always_comb
    begin
        r_d = r_q;
        r_d.wake_vector = 1'b0;
        r_d.wake_inline = 1'b0;
        r_d.core_restart = 1'b0;
        r_d.deep_in_prev = deep_sleep_request_n;

        // software write to flags clears bits written with one
        if (access && apb_req.pwrite && !widx[8] && widx[7:0] == SWC_IDX_FLAGS)
        begin
            r_d.flags = r_q.flags & ~apb_req.pwdata[5:0];
        end
        // a new event outranks a clear in the same cycle
        r_d.flags = r_d.flags | flag_set;

        // register writes other than flag clears take effect only while the core runs
        if (access && apb_req.pwrite && !widx[8] && r_q.mode == SWC_RUN)
        begin
            case (widx[7:0])
                SWC_IDX_POWER_CTRL:
                begin
                    r_d.power_ctrl = (apb_req.pwdata[7:0] & SWC_POWER_CTRL_WMASK)
                        & ~(8'h01 << SWC_DEEP_SLEEP_POS);
                end
                SWC_IDX_IRQ_MASK:
                begin
                    r_d.irq_mask = apb_req.pwdata[7:0];
                end
                SWC_IDX_PORT_CTRL:
                begin
                    r_d.port_ctrl = apb_req.pwdata[7:0];
                end
                default:
                begin
                    r_d.port_ctrl = r_d.port_ctrl;
                end
            endcase
            // soft sleep outranks idle when both bits are written
            if (apb_req.pwdata[SWC_SOFT_SLEEP_POS] && widx[7:0] == SWC_IDX_POWER_CTRL)
            begin
                r_d.mode = SWC_SOFT;
                r_d.mask_snap = r_q.irq_mask;
            end
            else if (apb_req.pwdata[SWC_LIGHT_SLEEP_POS]
                && widx[7:0] == SWC_IDX_POWER_CTRL)
            begin
                r_d.mode = SWC_IDLE;
                r_d.mask_snap = r_q.irq_mask;
            end
        end

        case (r_q.mode)
            SWC_RUN:
            begin
                r_d.mode = r_d.mode;
            end
            SWC_IDLE, SWC_SOFT:
            begin
                if (r_q.power_ctrl[SWC_RESUME_INLINE_POS] && any_hits != 6'h00)
                begin
                    r_d.mode = SWC_RUN;
                    r_d.wake_inline = 1'b1;
                end
                else if (!r_q.power_ctrl[SWC_RESUME_INLINE_POS]
                    && enabled_hits != 6'h00)
                begin
                    r_d.mode = SWC_RUN;
                    r_d.wake_vector = 1'b1;
                    r_d.vector_idx = first_set(enabled_hits);
                end
                if (r_d.mode == SWC_RUN)
                begin
                    r_d.power_ctrl[SWC_LIGHT_SLEEP_POS] = 1'b0;
                    r_d.power_ctrl[SWC_SOFT_SLEEP_POS] = 1'b0;
                end
            end
            SWC_DEEP:
            begin
                r_d.mode = SWC_DEEP;
            end
            default:
            begin
                r_d.mode = SWC_RUN;
            end
        endcase

        // falling edge on the shared timer pin enters deep sleep from any state
        if (r_q.deep_in_prev && !deep_sleep_request_n && r_q.mode != SWC_DEEP)
        begin
            r_d.mode = SWC_DEEP;
            r_d.power_ctrl[SWC_DEEP_SLEEP_POS] = 1'b1;
            r_d.float_q = r_q.port_ctrl[SWC_FLOAT_OUTPUTS_POS];
            r_d.wake_vector = 1'b0;
            r_d.wake_inline = 1'b0;
        end

        // reset pin must stay high for the least pulse width before it acts
        if (reset_pin)
        begin
            if (r_q.rst_cnt < 8'(RESET_MIN_CYC))
            begin
                r_d.rst_cnt = r_q.rst_cnt + 8'h01;
            end
        end
        else
        begin
            r_d.rst_cnt = 8'h00;
        end
        if (reset_pin && r_q.rst_cnt == 8'(RESET_MIN_CYC - 1))
        begin
            // core reset: everything to defaults, restart at address zero
            r_d = SWC_REGS_RST;
            r_d.rst_cnt = 8'(RESET_MIN_CYC);
            r_d.deep_in_prev = deep_sleep_request_n;
            r_d.core_restart = 1'b1;
        end

        // read data captured in the setup phase, shown in the access phase
        if (setup && !apb_req.pwrite)
        begin
            r_d.prdata = 32'h0000_0000;
            if (!widx[8])
            begin
                case (widx[7:0])
                    SWC_IDX_FLAGS: r_d.prdata[5:0] = r_q.flags;
                    SWC_IDX_STATUS: r_d.prdata[3:0] = {r_q.float_q, sleeping, r_q.mode};
                    SWC_IDX_POWER_CTRL: r_d.prdata[7:0] = r_q.power_ctrl;
                    SWC_IDX_IRQ_MASK: r_d.prdata[7:0] = r_q.irq_mask;
                    SWC_IDX_PORT_CTRL: r_d.prdata[7:0] = r_q.port_ctrl;
                    default: r_d.prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_q <= SWC_REGS_RST;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    always_comb
    begin
        apb_rsp.prdata = r_q.prdata;
        apb_rsp.pready = 1'b1;
        apb_rsp.pslverr = access && !is_mapped(widx);
        core_ctl.core_clk_en = (r_q.mode == SWC_RUN);
        core_ctl.osc_en = (r_q.mode == SWC_RUN) || (r_q.mode == SWC_IDLE);
        core_ctl.ports_float = (r_q.mode == SWC_DEEP) && r_q.float_q;
        core_ctl.wake_vector = r_q.wake_vector;
        core_ctl.wake_inline = r_q.wake_inline;
        core_ctl.vector_idx = r_q.vector_idx;
        core_ctl.core_restart = r_q.core_restart;
    end
endmodule : swc_sleep_wake_control

// ===== hdl/swc_pkg.sv
// shared constants and carrier types for the sleep and wake controller
package swc_pkg;
    // registers are word indices; byte address is four times the index
    localparam logic [7:0] SWC_IDX_FLAGS = 8'h00;
    localparam logic [7:0] SWC_IDX_STATUS = 8'h01;
    localparam logic [7:0] SWC_IDX_POWER_CTRL = 8'h87;
    localparam logic [7:0] SWC_IDX_IRQ_MASK = 8'hA8;
    localparam logic [7:0] SWC_IDX_PORT_CTRL = 8'hF8;
    localparam int SWC_ADDR_W = 12;

    // power control fields
    localparam int SWC_LIGHT_SLEEP_POS = 0;
    localparam int SWC_SOFT_SLEEP_POS = 1;
    localparam int SWC_GEN_FLAG_ZERO_POS = 2;
    localparam int SWC_GEN_FLAG_ONE_POS = 3;
    localparam int SWC_RESUME_INLINE_POS = 5;
    localparam int SWC_DEEP_SLEEP_POS = 6;
    localparam int SWC_BAUD_DOUBLE_POS = 7;
    localparam logic [7:0] SWC_POWER_CTRL_WMASK = 8'hEF;
    // irq mask fields: bits 0..5 per source, bit 7 global enable
    localparam int SWC_IRQ_GLOBAL_POS = 7;
    localparam int SWC_NUM_SRC = 6;
    // port control fields
    localparam int SWC_FLOAT_OUTPUTS_POS = 0;

    localparam logic [7:0] SWC_POWER_CTRL_RST = 8'h00;
    localparam logic [7:0] SWC_IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] SWC_PORT_CTRL_RST = 8'h00;

    // source order in flag and mask registers
    localparam int SWC_SRC_EXT0 = 0;
    localparam int SWC_SRC_TMR0 = 1;
    localparam int SWC_SRC_EXT1 = 2;
    localparam int SWC_SRC_TMR1 = 3;
    localparam int SWC_SRC_SERIAL = 4;
    localparam int SWC_SRC_TMR2 = 5;
    localparam logic [5:0] SWC_SOFT_WAKE_SRCS = 6'h0F;

    // least width of a reset pin pulse
    localparam int SWC_CLK_PERIOD_NS = 40;
    localparam int SWC_RESET_MIN_NS = 1000;
    localparam int SWC_RESET_MIN_CYC =
        (SWC_RESET_MIN_NS + SWC_CLK_PERIOD_NS - 1) / SWC_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SWC_RUN,
        SWC_IDLE,
        SWC_SOFT,
        SWC_DEEP
    } swc_mode_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [SWC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } swc_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } swc_apb_rsp_s;

    typedef struct packed {
        logic ext_irq_zero_n;
        logic ext_irq_one_n;
        logic tmr0_overflow;
        logic tmr1_overflow;
        logic serial_event;
        logic tmr2_event;
        logic tmr0_ext_clock;
        logic tmr1_ext_clock;
    } swc_irq_src_s;

    typedef struct packed {
        logic core_clk_en;
        logic osc_en;
        logic ports_float;
        logic wake_vector;
        logic wake_inline;
        logic [2:0] vector_idx;
        logic core_restart;
    } swc_core_ctl_s;
endpackage : swc_pkg

// ===== sim/swc_sleep_wake_chk.sv
// port assertions for the sleep and wake controller
`timescale 1ns/1ps
module swc_sleep_wake_chk #(
    parameter int RESET_MIN_CYC = swc_pkg::SWC_RESET_MIN_CYC
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset
    input wire swc_pkg::swc_apb_req_s apb_req, // apb request
    input wire swc_pkg::swc_apb_rsp_s apb_rsp, // apb response
    input wire swc_pkg::swc_irq_src_s irq_src, // sources
    input wire logic deep_sleep_request_n, // deep sleep input
    input wire logic reset_pin, // core reset pin
    input wire swc_pkg::swc_core_ctl_s core_ctl // core control
);
    import swc_pkg::*;
    logic [7:0] hi_cnt_q;
    logic wr_pwr;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // consecutive edges with the reset pin high
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            hi_cnt_q <= 8'h00;
        else if (!reset_pin)
            hi_cnt_q <= 8'h00;
        else if (hi_cnt_q != 8'hFF)
            hi_cnt_q <= hi_cnt_q + 8'h01;
    assign wr_pwr = apb_req.psel && apb_req.penable && apb_req.pwrite && !reset_pin
        && apb_req.paddr == {2'b00, SWC_IDX_POWER_CTRL, 2'b00} && core_ctl.core_clk_en
        && deep_sleep_request_n;
    a_soft_entry: assert property (wr_pwr && apb_req.pwdata[1] |=>
        !core_ctl.core_clk_en && !core_ctl.osc_en) else $error("soft sleep not entered");
    a_idle_entry: assert property (wr_pwr && apb_req.pwdata[1:0] == 2'b01 |=>
        !core_ctl.core_clk_en && core_ctl.osc_en) else $error("idle not entered");
    a_deep_entry: assert property ($fell(deep_sleep_request_n) && !reset_pin |=>
        !core_ctl.core_clk_en && !core_ctl.osc_en) else $error("deep sleep not entered");
    a_float_deep: assert property (core_ctl.ports_float |->
        !core_ctl.osc_en && !core_ctl.core_clk_en) else $error("ports float while awake");
    a_float_cause: assert property ($rose(core_ctl.ports_float) |->
        !$past(deep_sleep_request_n)) else $error("float without deep request");
    a_deep_exit: assert property (core_ctl.ports_float |=>
        core_ctl.ports_float || core_ctl.core_restart) else $error("deep left without reset");
    a_restart_time: assert property ((hi_cnt_q == 8'(RESET_MIN_CYC))
        == core_ctl.core_restart) else $error("restart pulse mistimed");
    a_restart_run: assert property (core_ctl.core_restart |-> core_ctl.core_clk_en
        && core_ctl.osc_en && !core_ctl.ports_float) else $error("restart not running");
    a_wake_cause: assert property ($rose(core_ctl.core_clk_en) |->
        core_ctl.wake_vector || core_ctl.wake_inline || core_ctl.core_restart)
        else $error("clock back without cause");
    a_wake_pulse: assert property (core_ctl.wake_vector || core_ctl.wake_inline |->
        core_ctl.core_clk_en && !(core_ctl.wake_vector && core_ctl.wake_inline)
        ##1 !core_ctl.wake_vector && !core_ctl.wake_inline) else $error("bad wake pulse");
    c_vector: cover property (core_ctl.wake_vector);
    c_inline: cover property (core_ctl.wake_inline);
    c_deep_restart: cover property (core_ctl.ports_float ##1 core_ctl.core_restart);
endmodule : swc_sleep_wake_chk

// ===== sim/swc_pfail_model.sv
// power failure detector and reset circuit beside the controller
`timescale 1ns/1ps
module swc_pfail_model #(
    parameter int DELAY_CYC = 4,
    parameter int HOLD_CYC = swc_pkg::SWC_RESET_MIN_CYC
) (
    input wire logic pclk, // clock
    input wire logic fail, // supply lost while high
    input wire logic rst_req, // manual reset request
    input wire logic bus_busy, // ram transfer under way
    output logic ram_iso_n, // low isolates the ram
    output logic deep_sleep_request_n, // deep sleep request
    output logic reset_pin // core reset, active high
);
    logic down_q = 1'b0;
    int cnt_q = 0;
    int hold_q = 0;
    initial deep_sleep_request_n = 1'b1;
    always @(posedge pclk)
    begin
        if (!down_q && fail && !bus_busy)
        begin
            down_q <= 1'b1;
            deep_sleep_request_n <= 1'b0;
            cnt_q <= 0;
        end
        if (down_q && !fail)
            cnt_q <= cnt_q + 1;
        if (down_q && !fail && cnt_q == DELAY_CYC)
        begin
            down_q <= 1'b0;
            deep_sleep_request_n <= 1'b1;
        end
        if ((down_q && !fail && cnt_q == DELAY_CYC) || rst_req)
            hold_q <= HOLD_CYC;
        else if (hold_q != 0)
            hold_q <= hold_q - 1;
    end
    assign ram_iso_n = !down_q;
    assign reset_pin = hold_q != 0;
endmodule : swc_pfail_model

// ===== sim/tb.sv
// self-checking bench for the sleep and wake controller
`timescale 1ns/1ps
module tb;
    import swc_pkg::*;
    localparam logic [11:0] A_FLG = 12'h000;
    localparam logic [11:0] A_STA = 12'h004;
    localparam logic [11:0] A_PWR = {2'b00, SWC_IDX_POWER_CTRL, 2'b00};
    localparam logic [11:0] A_MSK = {2'b00, SWC_IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_PRT = {2'b00, SWC_IDX_PORT_CTRL, 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic fail = 1'b0;
    logic rst_req = 1'b0;
    logic deep_n;
    logic rst_pin;
    swc_apb_req_s req = '0;
    swc_apb_rsp_s rsp;
    swc_irq_src_s irq = 8'hC0;
    swc_core_ctl_s ctl;
    logic [5:0] wk;
    logic [32:0] exp_rd[$];
    logic [5:0] exp_wk[$];
    logic [31:0] seed = 32'h0000000D;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    always #20 pclk = ~pclk;
    swc_sleep_wake_control #(.RESET_MIN_CYC(2)) u_swc_sleep_wake_control (.pclk(pclk),
        .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .irq_src(irq),
        .deep_sleep_request_n(deep_n), .reset_pin(rst_pin), .core_ctl(ctl));
    swc_pfail_model u_swc_pfail_model (.pclk(pclk), .fail(fail), .rst_req(rst_req),
        .bus_busy(req.psel), .ram_iso_n(), .deep_sleep_request_n(deep_n), .reset_pin(rst_pin));
    assign wk = {ctl.wake_vector, ctl.wake_inline, ctl.core_restart,
        ctl.wake_vector ? ctl.vector_idx : 3'h0};
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction : xs
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic drive(input int s, input logic on);
        case (s)
            0: irq.ext_irq_zero_n <= !on;
            1: irq.tmr0_overflow <= on;
            2: irq.ext_irq_one_n <= !on;
            3: irq.tmr1_overflow <= on;
            4: irq.serial_event <= on;
            default: irq.tmr2_event <= on;
        endcase
    endtask : drive
    task automatic pulse(input int s);
        @(posedge pclk);
        drive(s, 1'b1);
        @(posedge pclk);
        drive(s, 1'b0);
        repeat (4) @(posedge pclk);
    endtask : pulse
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            results();
        end
        if (req.psel && req.penable && !req.pwrite && rsp.pready)
            check({rsp.pslverr, rsp.prdata}, exp_rd.pop_front());
        if (wk[5:3] != 3'b000)
            check({27'h0, wk}, {27'h0, exp_wk.size() ? exp_wk.pop_front() : 6'h3F});
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_PWR, 33'h0);
        rd(A_MSK, 33'h0);
        rd(12'h400, {1'b1, 32'h0});
        rd(12'h208, {1'b1, 32'h0});
        apb(1'b1, A_PWR, 32'h000000FC);
        rd(A_PWR, 33'h0AC);
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            apb(1'b1, A_PRT, seed);
            rd(A_PRT, {25'h0, seed[7:0]});
        end
        for (int m = 0; m < 2; m++)
            for (int s = 0; s < 6; s++)
            begin
                seed = xs(seed);
                apb(1'b1, A_MSK, m ? {24'h0, seed[7:0]} : 32'h80 | (32'h1 << s));
                apb(1'b1, A_PWR, m ? 32'h21 : 32'h01);
                exp_wk.push_back(m ? 6'h10 : {3'b100, 3'(s)});
                pulse(s);
                check({32'h0, ctl.core_clk_en}, 33'h1);
                rd(A_FLG, 33'h1 << s);
                apb(1'b1, A_FLG, 32'h3F);
            end
        apb(1'b1, A_MSK, 32'h7F);
        apb(1'b1, A_PWR, 32'h01);
        pulse(0);
        check({32'h0, ctl.core_clk_en}, 33'h0);
        exp_wk.push_back(6'h08);
        rst_req <= 1'b1;
        @(posedge pclk);
        rst_req <= 1'b0;
        repeat (6) @(posedge pclk);
        // the detector holds the reset pin for its full minimum width
        while (rst_pin)
            @(posedge pclk);
        rd(A_PWR, 33'h0);
        apb(1'b1, A_PWR, 32'h22);
        pulse(4);
        pulse(1);
        check({32'h0, ctl.osc_en}, 33'h0);
        irq.tmr1_ext_clock <= 1'b1;
        exp_wk.push_back(6'h10);
        pulse(3);
        rd(A_FLG, 33'h1A);
        apb(1'b1, A_FLG, 32'h3F);
        apb(1'b1, A_MSK, 32'h84);
        apb(1'b1, A_PWR, 32'h02);
        exp_wk.push_back(6'h22);
        pulse(2);
        check({32'h0, ctl.osc_en}, 33'h1);
        apb(1'b1, A_PRT, 32'h01);
        fail <= 1'b1;
        repeat (4) @(posedge pclk);
        check({31'h0, ctl.osc_en, ctl.ports_float}, 33'h1);
        rd(A_STA, 33'h0B);
        pulse(0);
        exp_wk.push_back(6'h08);
        fail <= 1'b0;
        repeat (12) @(posedge pclk);
        check({31'h0, ctl.osc_en, ctl.ports_float}, 33'h2);
        results();
    end
endmodule : tb
bind swc_sleep_wake_control swc_sleep_wake_chk #(.RESET_MIN_CYC(RESET_MIN_CYC))
    u_swc_sleep_wake_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .irq_src(irq_src), .deep_sleep_request_n(deep_sleep_request_n),
    .reset_pin(reset_pin), .core_ctl(core_ctl));
